// File: core/mmc_pkg.sv
package mmc_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] INT_TOP = 32'h0040_0000;
  localparam logic [31:0] PER_BASE = 32'hffc0_0000;
  localparam logic [31:0] SRAM_BYTES = 32'h0000_2000;
  localparam logic [31:0] SRAM_BOOT_BASE = 32'h0030_0000;
  localparam int SRAM_WORDS = 2048;
  localparam int SRAM_AW = 11;
  localparam int WORD_LSB = 2;

  // ----------------------------------------------------------------
  // External banks
  // ----------------------------------------------------------------
  localparam int NBANKS = 8;
  localparam int BANK_IDX_W = 3;
  localparam int BANK_BASE_LSB = 20;
  localparam int BANK_BASE_W = 12;
  localparam int SIZE_CODE_W = 3;
  localparam logic [2:0] SIZE_CODE_MAX = 3'h4;
  localparam int WAIT_W = 3;
  localparam int FLOAT_W = 3;

  // ----------------------------------------------------------------
  // Peripheral windows
  // ----------------------------------------------------------------
  localparam int PER_WIN_LSB = 14;
  localparam int PER_IDX_W = 8;
  localparam int PER_WINDOWS = 256;
  localparam logic [7:0] AIC_IDX = 8'hff;
  localparam int AIC_WIN_LSB = 12;

  // ----------------------------------------------------------------
  // Access sizes, abort sources, reset timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] ABT_NONE = 2'h0;
  localparam logic [1:0] ABT_UNDEF = 2'h1;
  localparam logic [1:0] ABT_PROTECT = 2'h2;
  localparam logic [1:0] ABT_MISALIGN = 2'h3;
  localparam int BOOT_WINDOW = 10;
  localparam int SLOW_SYNC_EDGES = 2;

  typedef enum {MMC_IDLE, MMC_EXT, MMC_PER, MMC_DONE} mmc_state_t;

endpackage

// File: core/mmc_sram.sv
`timescale 1ns/1ps
module mmc_sram #(
  parameter int WORDS = mmc_pkg::SRAM_WORDS,
  parameter int AW = mmc_pkg::SRAM_AW
) (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic en,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  initial begin
    if (WORDS > (1 << AW)) begin
      $error("mmc_sram: depth exceeds address width");
    end
  end

  logic [31:0] mem [WORDS];

  // Little-endian lanes: byte 0 sits in bits 7:0
  always_ff @(posedge sys_clk) begin
    if (clk_en && en) begin
      for (int i = 0; i < 4; i++) begin
        if (we && be[i]) begin
          mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
      rdata <= mem[addr];
    end
  end
endmodule

// File: core/mmc_reset_ctrl.sv
`timescale 1ns/1ps
module mmc_reset_ctrl (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic slow_clock,
  input wire logic external_reset_n,
  input wire logic watchdog_reset,
  input wire logic boot_width_select,
  input wire logic tristate_request_n,
  output logic dev_reset_n,
  output logic boot_mode_8bit,
  output logic tristate_mode
);
  logic ext_q;
  logic slow_q;
  logic held;
  logic [1:0] edge_cnt;
  logic [mmc_pkg::BOOT_WINDOW-1:0] bms_hist;
  logic [mmc_pkg::BOOT_WINDOW-1:0] tri_hist;
  logic slow_rise;
  logic ext_rise;

  assign slow_rise = slow_clock && !slow_q;
  assign ext_rise = external_reset_n && !ext_q;
  assign dev_reset_n = external_reset_n && !held && !watchdog_reset;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ext_q <= 1'b1;
      slow_q <= 1'b0;
    end else if (clk_en) begin
      ext_q <= external_reset_n;
      slow_q <= slow_clock;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      held <= 1'b1;
      edge_cnt <= 2'h0;
    end else if (clk_en) begin
      if (!external_reset_n || watchdog_reset) begin
        held <= 1'b1;
        edge_cnt <= 2'h0;
      end else if (held && slow_rise) begin
        if (edge_cnt == 2'(mmc_pkg::SLOW_SYNC_EDGES - 1)) begin
          held <= 1'b0;
        end
        edge_cnt <= edge_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bms_hist <= '0;
      tri_hist <= '1;
    end else if (clk_en && !external_reset_n) begin
      bms_hist <= {bms_hist[mmc_pkg::BOOT_WINDOW-2:0], boot_width_select};
      tri_hist <= {tri_hist[mmc_pkg::BOOT_WINDOW-2:0], tristate_request_n};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      boot_mode_8bit <= 1'b0;
      tristate_mode <= 1'b0;
    end else if (clk_en && ext_rise) begin
      if (&bms_hist || ~|bms_hist) begin
        boot_mode_8bit <= bms_hist[0];
      end
      if (&tri_hist || ~|tri_hist) begin
        tristate_mode <= !tri_hist[0];
      end
    end
  end

  a_ext_assert: assert property (@(posedge sys_clk) disable iff (!resetn)
    !external_reset_n |-> !dev_reset_n) else $error("reset not asserted");
  a_slow_release: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
    $rose(!held) |-> $past(slow_rise)) else $error("release off slow edge");
endmodule

// File: core/mmc_memory_map_controller.sv
// What this block does
// - Split the 32-bit address into internal, external and peripheral regions.
// - Send addresses from 0x0040_0000 below 0xFFC0_0000 to the external bus.
// - External banks sized one to sixteen megabytes; byte, half, word accesses.
// - Per bank wait states, float cycles, width, pairing mode; one early read setting for all banks.
// - Little-endian byte lanes everywhere.
// - Internal SRAM is 32 bits wide, one cycle per access.
// - After remap the 8-Kbyte SRAM appears at address zero.
// - Boot width level caught over the last 10 cycles before reset rises.
// - Boot width 1 means 8-bit chip select zero, 0 means 16-bit.
// - Before remap address zero reaches the boot memory.
// - Writing one to the remap bit maps the SRAM low.
// - Remap holds until internal or external reset.
// - Watchdog reset acts like external reset but keeps latched modes.
// - Coinciding resets count as external, modes resampled.
// - Abort on undefined external address or protected write; cancel the write.
// - Misaligned half or word access aborts but still proceeds.
// - No abort on internal memory reads or on any peripheral access.
// - Forbidden writes to mode-protected peripherals dropped silently.
// - Record abort source, address and type in status outputs.
// - Peripheral accesses forced to words by clearing low address bits.
// - Peripherals get 16-Kbyte windows, the interrupt controller 4 Kbytes.
// - External reset acts at once, releases on the slow clock.
`timescale 1ns/1ps
module mmc_memory_map_controller #(
  parameter int NB = mmc_pkg::NBANKS,
  parameter logic [mmc_pkg::PER_WINDOWS-1:0] PROTECTED_WINDOWS = '0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic slow_clock,
  input wire logic external_reset_n,
  input wire logic watchdog_reset,
  input wire logic boot_width_select,
  input wire logic tristate_request_n,
  input wire logic remap_command_bit,
  input wire logic cpu_req,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_fetch,
  input wire logic cpu_priv,
  output logic [31:0] cpu_rdata,
  output logic cpu_ready,
  output logic cpu_abort,
  input wire logic [NB-1:0] bank_enable,
  input wire logic [NB*mmc_pkg::BANK_BASE_W-1:0] bank_base,
  input wire logic [NB*mmc_pkg::SIZE_CODE_W-1:0] bank_size_code,
  input wire logic [NB-1:0] bank_write_protect,
  input wire logic [NB*mmc_pkg::WAIT_W-1:0] bank_wait_states,
  input wire logic [NB*mmc_pkg::FLOAT_W-1:0] bank_float_cycles,
  input wire logic [NB-1:0] bank_width16,
  input wire logic [NB-1:0] bank_byte_write_mode,
  input wire logic early_read,
  output logic ebu_req,
  output logic [31:0] ebu_addr,
  output logic ebu_write,
  output logic [1:0] ebu_size,
  output logic [31:0] ebu_wdata,
  output logic [mmc_pkg::BANK_IDX_W-1:0] ebu_bank,
  output logic [mmc_pkg::WAIT_W-1:0] ebu_wait_states,
  output logic [mmc_pkg::FLOAT_W-1:0] ebu_float_cycles,
  output logic ebu_width16,
  output logic ebu_byte_write_mode,
  output logic ebu_early_read,
  input wire logic ebu_ready,
  input wire logic [31:0] ebu_rdata,
  output logic per_req,
  output logic [31:0] per_addr,
  output logic per_write,
  output logic [31:0] per_wdata,
  output logic [mmc_pkg::PER_IDX_W-1:0] per_index,
  output logic per_aic_sel,
  input wire logic per_ready,
  input wire logic [31:0] per_rdata,
  output logic dev_reset_n,
  output logic remapped,
  output logic boot_mode_8bit,
  output logic tristate_mode,
  output logic [1:0] abort_source,
  output logic [31:0] abort_addr,
  output logic abort_fetch,
  output logic abort_write
);
  initial begin
    if (NB != mmc_pkg::NBANKS) begin
      $error("mmc: bank count must be eight");
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic bank_match(input logic [31:0] a, input logic [11:0] base,
                                      input logic [2:0] code);
    logic [11:0] mask;
    logic [2:0] c;
    c = (code > mmc_pkg::SIZE_CODE_MAX) ? mmc_pkg::SIZE_CODE_MAX : code;
    mask = ~((12'h1 << c) - 12'h1);
    bank_match = ((a[31:mmc_pkg::BANK_BASE_LSB] ^ base) & mask) == 12'h0;
  endfunction
  function automatic logic [3:0] byte_lanes(input logic [1:0] sz, input logic [1:0] lo);
    case (sz)
      mmc_pkg::SZ_BYTE: byte_lanes = 4'h1 << lo;
      mmc_pkg::SZ_HALF: byte_lanes = lo[1] ? 4'hc : 4'h3;
      default: byte_lanes = 4'hf;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reset and boot mode
  // ----------------------------------------------------------------
  mmc_reset_ctrl u_reset (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .slow_clock(slow_clock),
    .external_reset_n(external_reset_n),
    .watchdog_reset(watchdog_reset),
    .boot_width_select(boot_width_select),
    .tristate_request_n(tristate_request_n),
    .dev_reset_n(dev_reset_n),
    .boot_mode_8bit(boot_mode_8bit),
    .tristate_mode(tristate_mode)
  );

  logic rst;
  assign rst = !resetn || !dev_reset_n;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      remapped <= 1'b0;
    end else if (clk_en && remap_command_bit) begin
      remapped <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [NB-1:0] hit;
  logic is_int;
  logic is_per;
  logic is_ext;
  logic sram_hit;
  logic boot_route;
  logic ext_route;
  logic undef;
  logic protect;
  logic misal;
  logic abort_now;
  logic per_drop;
  logic [mmc_pkg::BANK_IDX_W-1:0] bank_sel;
  logic [mmc_pkg::PER_IDX_W-1:0] pidx;
  logic [31:0] sram_off;
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_bank
      // bank window, upper selects after remap
      assign hit[g] = bank_enable[g] && (remapped || g == 0) &&
                      bank_match(cpu_addr, bank_base[g*mmc_pkg::BANK_BASE_W +: mmc_pkg::BANK_BASE_W],
                                 bank_size_code[g*mmc_pkg::SIZE_CODE_W +: mmc_pkg::SIZE_CODE_W]);
    end
  endgenerate

  always_comb begin
    bank_sel = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (hit[i]) begin
        bank_sel = mmc_pkg::BANK_IDX_W'(i);
      end
    end
  end

  assign is_int = cpu_addr < mmc_pkg::INT_TOP;
  assign is_per = cpu_addr >= mmc_pkg::PER_BASE;
  assign is_ext = !is_int && !is_per;
  assign sram_off = remapped ? cpu_addr : cpu_addr - mmc_pkg::SRAM_BOOT_BASE;
  assign sram_hit = is_int && (remapped ? cpu_addr < mmc_pkg::SRAM_BYTES :
                    (cpu_addr >= mmc_pkg::SRAM_BOOT_BASE &&
                     cpu_addr < mmc_pkg::SRAM_BOOT_BASE + mmc_pkg::SRAM_BYTES));
  assign boot_route = is_int && !remapped && !sram_hit;
  assign ext_route = (is_ext && |hit) || boot_route;
  assign undef = is_ext && !(|hit);
  assign protect = ext_route && cpu_write && bank_write_protect[boot_route ? '0 : bank_sel];
  assign misal = (cpu_size == mmc_pkg::SZ_HALF && cpu_addr[0]) ||
                 (cpu_size == mmc_pkg::SZ_WORD && cpu_addr[1:0] != 2'h0);
  // no abort on internal reads or peripherals
  assign abort_now = !is_per && (undef || protect || (misal && !(is_int && !boot_route && !cpu_write)));
  assign pidx = cpu_addr[mmc_pkg::PER_WIN_LSB +: mmc_pkg::PER_IDX_W];
  assign per_drop = (cpu_write && !cpu_priv && PROTECTED_WINDOWS[pidx]) ||
                    (pidx == mmc_pkg::AIC_IDX &&
                     cpu_addr[mmc_pkg::PER_WIN_LSB-1:mmc_pkg::AIC_WIN_LSB] != '0);

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  mmc_pkg::mmc_state_t state;
  logic take;
  logic sram_en;
  logic rd_sram;
  logic abort_q;
  logic [31:0] rdata_q;
  logic [31:0] sram_rdata;

  assign take = clk_en && state == mmc_pkg::MMC_IDLE && cpu_req;
  assign sram_en = take && sram_hit;
  mmc_sram u_sram (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .en(sram_en),
    .we(cpu_write),
    .be(byte_lanes(cpu_size, cpu_addr[1:0])),
    .addr(sram_off[mmc_pkg::WORD_LSB +: mmc_pkg::SRAM_AW]),
    .wdata(cpu_wdata),
    .rdata(sram_rdata)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= mmc_pkg::MMC_IDLE;
    end else if (clk_en) begin
      case (state)
        mmc_pkg::MMC_IDLE: begin
          if (cpu_req) begin
            if (ext_route && !protect) begin
              state <= mmc_pkg::MMC_EXT;
            end else if (is_per && !per_drop) begin
              state <= mmc_pkg::MMC_PER;
            end else begin
              state <= mmc_pkg::MMC_DONE;
            end
          end
        end
        mmc_pkg::MMC_EXT: begin
          if (ebu_ready) begin
            state <= mmc_pkg::MMC_DONE;
          end
        end
        mmc_pkg::MMC_PER: begin
          if (per_ready) begin
            state <= mmc_pkg::MMC_DONE;
          end
        end
        default: state <= mmc_pkg::MMC_IDLE;
      endcase
    end
  end

  assign cpu_ready = state == mmc_pkg::MMC_DONE;
  assign cpu_abort = cpu_ready && abort_q;
  assign cpu_rdata = rd_sram ? sram_rdata : rdata_q;
  assign ebu_req = state == mmc_pkg::MMC_EXT;
  assign per_req = state == mmc_pkg::MMC_PER;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= '0;
      rd_sram <= 1'b0;
      abort_q <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        rdata_q <= '0;
        rd_sram <= sram_hit;
        abort_q <= abort_now;
      end else if (state == mmc_pkg::MMC_EXT && ebu_ready) begin
        rdata_q <= ebu_rdata;
      end else if (state == mmc_pkg::MMC_PER && per_ready) begin
        rdata_q <= per_rdata;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ebu_addr <= '0;
      ebu_write <= 1'b0;
      ebu_size <= mmc_pkg::SZ_WORD;
      ebu_wdata <= '0;
      ebu_bank <= '0;
      ebu_wait_states <= '0;
      ebu_float_cycles <= '0;
      ebu_width16 <= 1'b0;
      ebu_byte_write_mode <= 1'b0;
      ebu_early_read <= 1'b0;
    end else if (take && ext_route) begin
      ebu_addr <= cpu_addr;
      ebu_write <= cpu_write;
      ebu_size <= cpu_size;
      ebu_wdata <= cpu_wdata;
      ebu_bank <= boot_route ? '0 : bank_sel;
      ebu_wait_states <= bank_wait_states[(boot_route ? 0 : int'(bank_sel))*mmc_pkg::WAIT_W +: mmc_pkg::WAIT_W];
      ebu_float_cycles <= bank_float_cycles[(boot_route ? 0 : int'(bank_sel))*mmc_pkg::FLOAT_W +: mmc_pkg::FLOAT_W];
      ebu_width16 <= boot_route ? !boot_mode_8bit : bank_width16[bank_sel];
      ebu_byte_write_mode <= boot_route ? 1'b0 : bank_byte_write_mode[bank_sel];
      ebu_early_read <= early_read;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      per_addr <= '0;
      per_write <= 1'b0;
      per_wdata <= '0;
      per_index <= '0;
      per_aic_sel <= 1'b0;
    end else if (take && is_per) begin
      per_addr <= {cpu_addr[31:mmc_pkg::WORD_LSB], 2'h0};
      per_write <= cpu_write;
      per_wdata <= cpu_wdata;
      per_index <= pidx;
      per_aic_sel <= pidx == mmc_pkg::AIC_IDX;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      abort_source <= mmc_pkg::ABT_NONE;
      abort_addr <= '0;
      abort_fetch <= 1'b0;
      abort_write <= 1'b0;
    end else if (take && abort_now) begin
      abort_source <= undef ? mmc_pkg::ABT_UNDEF : protect ? mmc_pkg::ABT_PROTECT : mmc_pkg::ABT_MISALIGN;
      abort_addr <= cpu_addr;
      abort_fetch <= cpu_fetch;
      abort_write <= cpu_write;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !clk_en);

  a_sram_one_cycle: assert property (sram_en |=> cpu_ready) else $error("sram slow");
  a_peri_word: assert property (per_req |-> per_addr[1:0] == 2'h0) else $error("periph not word");
  a_peri_no_abort: assert property (state == mmc_pkg::MMC_PER && per_ready |=> cpu_ready && !cpu_abort)
    else $error("periph abort");
  a_protect_cancel: assert property (take && protect |=> cpu_ready && cpu_abort && !ebu_req)
    else $error("protected write passed");
  a_misal_proceed: assert property (take && ext_route && misal && !protect |=> ebu_req ##[0:1000] cpu_abort)
    else $error("misaligned cancelled");
  a_ext_range: assert property (ebu_req && remapped |-> ebu_addr >= mmc_pkg::INT_TOP && ebu_addr < mmc_pkg::PER_BASE)
    else $error("external out of range");
  a_remap_sticky: assert property ($fell(remapped) |-> $past(!dev_reset_n)) else $error("remap lost");
  a_remap_set: assert property (remap_command_bit |=> remapped) else $error("remap missing");
  a_boot_width: assert property (take && boot_route |=> ebu_width16 == !boot_mode_8bit)
    else $error("boot width wrong");
  a_low_sram: assert property (take && remapped && cpu_addr < mmc_pkg::SRAM_BYTES |-> sram_en)
    else $error("sram not at zero");
  a_status_record: assert property (cpu_abort |-> abort_source != mmc_pkg::ABT_NONE)
    else $error("abort unrecorded");

  c_remap: cover property (remap_command_bit ##1 remapped);
  c_ext_done: cover property (ebu_req ##1 cpu_ready);
  c_abort: cover property (cpu_abort && abort_source == mmc_pkg::ABT_MISALIGN);
endmodule

// File: testbench/mmc_far_model.sv
`timescale 1ns/1ps
module mmc_far_model #(
  parameter int EDLY = 3,
  parameter int PDLY = 0
) (
  input wire logic sys_clk,
  input wire logic ebu_req,
  input wire logic [31:0] ebu_addr,
  output logic ebu_ready,
  output logic [31:0] ebu_rdata,
  input wire logic per_req,
  input wire logic [31:0] per_addr,
  output logic per_ready,
  output logic [31:0] per_rdata
);
  int ecnt = 0;
  int pcnt = 0;
  initial begin
    ebu_ready = 1'h0;
    per_ready = 1'h0;
    ebu_rdata = 32'h0;
    per_rdata = 32'h0;
  end
  // One answer per request; data churns when not answering
  always @(posedge sys_clk) begin
    ebu_ready <= 1'h0;
    ebu_rdata <= ~ebu_rdata;
    if (!ebu_req) begin
      ecnt <= 0;
    end else if (ecnt <= EDLY) begin
      ecnt <= ecnt + 1;
      if (ecnt == EDLY) begin
        ebu_ready <= 1'h1;
        ebu_rdata <= ebu_addr ^ 32'h5a5a_0000;
      end
    end
  end
  always @(posedge sys_clk) begin
    per_ready <= 1'h0;
    per_rdata <= ~per_rdata;
    if (!per_req) begin
      pcnt <= 0;
    end else if (pcnt <= PDLY) begin
      pcnt <= pcnt + 1;
      if (pcnt == PDLY) begin
        per_ready <= 1'h1;
        per_rdata <= per_addr;
      end
    end
  end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk, resetn, clk_en, slow_clock, external_reset_n, watchdog_reset, boot_width_select;
  logic tristate_request_n, remap_command_bit, cpu_req, cpu_write, cpu_fetch, cpu_priv, early_read;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, ebu_addr, ebu_wdata, ebu_rdata, per_addr, per_wdata, per_rdata;
  logic [31:0] abort_addr;
  logic [1:0] cpu_size, ebu_size, abort_source;
  logic [7:0] bank_enable, bank_write_protect, bank_width16, bank_byte_write_mode, per_index;
  logic [95:0] bank_base;
  logic [23:0] bank_size_code, bank_wait_states, bank_float_cycles;
  logic [2:0] ebu_bank, ebu_wait_states, ebu_float_cycles, sdiv;
  logic cpu_ready, cpu_abort, ebu_req, ebu_write, ebu_width16, ebu_byte_write_mode, ebu_early_read, ebu_ready;
  logic per_req, per_write, per_aic_sel, per_ready, dev_reset_n, remapped, boot_mode_8bit, tristate_mode;
  logic abort_fetch, abort_write;
  logic [31:0] r_data, r_paddr;
  logic [7:0] r_pidx;
  logic [2:0] r_bank;
  logic r_abort, r_ebu, r_per, r_w16, r_aic;
  int r_cyc, err_total, total_checks;

  mmc_memory_map_controller #(.PROTECTED_WINDOWS(256'h2)) mmc_memory_map_controller_inst (.sys_clk, .resetn,
    .clk_en, .slow_clock, .external_reset_n, .watchdog_reset, .boot_width_select, .tristate_request_n,
    .remap_command_bit, .cpu_req, .cpu_addr, .cpu_write, .cpu_size, .cpu_wdata, .cpu_fetch, .cpu_priv,
    .cpu_rdata, .cpu_ready, .cpu_abort, .bank_enable, .bank_base, .bank_size_code, .bank_write_protect,
    .bank_wait_states, .bank_float_cycles, .bank_width16, .bank_byte_write_mode, .early_read, .ebu_req,
    .ebu_addr, .ebu_write, .ebu_size, .ebu_wdata, .ebu_bank, .ebu_wait_states, .ebu_float_cycles, .ebu_width16,
    .ebu_byte_write_mode, .ebu_early_read, .ebu_ready, .ebu_rdata, .per_req, .per_addr, .per_write, .per_wdata,
    .per_index, .per_aic_sel, .per_ready, .per_rdata, .dev_reset_n, .remapped, .boot_mode_8bit, .tristate_mode,
    .abort_source, .abort_addr, .abort_fetch, .abort_write);
  mmc_far_model mmc_far_model_inst (.sys_clk, .ebu_req, .ebu_addr, .ebu_ready, .ebu_rdata, .per_req,
    .per_addr, .per_ready, .per_rdata);

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    sdiv <= sdiv + 3'h1;
    slow_clock <= sdiv[2];
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic [31:0] d, input logic pv);
    r_cyc = 0;
    r_ebu = 1'h0;
    r_per = 1'h0;
    @(posedge sys_clk);
    cpu_req <= 1'h1;
    cpu_addr <= a;
    cpu_write <= w;
    cpu_size <= sz;
    cpu_wdata <= d;
    cpu_priv <= pv;
    do begin
      @(posedge sys_clk);
      r_cyc++;
      if (ebu_req === 1'h1) begin
        r_ebu = 1'h1;
        r_bank = ebu_bank;
        r_w16 = ebu_width16;
      end
      if (per_req === 1'h1) begin
        r_per = 1'h1;
        r_paddr = per_addr;
        r_pidx = per_index;
        r_aic = per_aic_sel;
      end
    end while (cpu_ready !== 1'h1 && r_cyc < 40);
    chk("cpu_ready", 1, cpu_ready);
    cpu_req <= 1'h0;
    r_data = cpu_rdata;
    r_abort = cpu_abort;
  endtask

  task do_reset(input logic bws, input logic ext, input logic wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    boot_width_select <= bws;
    external_reset_n <= !ext;
    watchdog_reset <= wd;
    repeat (12) @(posedge sys_clk);
    external_reset_n <= 1'h1;
    watchdog_reset <= 1'h0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (dev_reset_n !== 1'h1 && n < 100);
    chk("dev_reset_n", 1, dev_reset_n);
  endtask

  task t_boot;
    chk("boot_mode_8bit", 1, boot_mode_8bit);
    chk("tristate_mode", 0, tristate_mode);
    acc(32'h0, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h1);
    chk("boot_ebu", 1, r_ebu);
    chk("boot_bank", 0, r_bank);
    chk("boot_w16", 0, r_w16);
    chk("boot_data", 32'h5a5a_0000, r_data);
  endtask

  task t_remap;
    @(posedge sys_clk);
    remap_command_bit <= 1'h1;
    @(posedge sys_clk);
    remap_command_bit <= 1'h0;
    @(posedge sys_clk);
    chk("remapped", 1, remapped);
    acc(32'h0, 1'h1, mmc_pkg::SZ_WORD, 32'h1122_3344, 1'h1);
    chk("sram_ebu", 0, r_ebu);
    acc(32'h1, 1'h1, mmc_pkg::SZ_BYTE, 32'habab_abab, 1'h1);
    acc(32'h0, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h1);
    chk("sram_data", 32'h1122_ab44, r_data);
    chk("sram_cycles", 2, r_cyc);
    chk("sram_abort", 0, r_abort);
  endtask

  task t_aborts;
    // Remap already done, so chip select one may be used
    acc(32'h0100_0004, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h1);
    chk("bank1_sel", 1, r_bank);
    chk("bank1_abort", 0, r_abort);
    chk("bank1_wait", 3, ebu_wait_states);
    chk("bank1_float", 5, ebu_float_cycles);
    chk("early_read", 1, ebu_early_read);
    acc(32'h0100_0000, 1'h1, mmc_pkg::SZ_WORD, 32'h55, 1'h1);
    chk("prot_abort", 1, r_abort);
    chk("prot_ebu", 0, r_ebu);
    chk("prot_src", mmc_pkg::ABT_PROTECT, abort_source);
    chk("prot_write", 1, abort_write);
    acc(32'h2000_0000, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h1);
    chk("undef_abort", 1, r_abort);
    chk("undef_ebu", 0, r_ebu);
    chk("undef_src", mmc_pkg::ABT_UNDEF, abort_source);
    chk("undef_addr", 32'h2000_0000, abort_addr);
    acc(32'h0040_0001, 1'h0, mmc_pkg::SZ_HALF, 32'h0, 1'h1);
    chk("mis_abort", 1, r_abort);
    chk("mis_ebu", 1, r_ebu);
    chk("mis_src", mmc_pkg::ABT_MISALIGN, abort_source);
  endtask

  task t_periph;
    acc(32'hfff0_4003, 1'h0, mmc_pkg::SZ_BYTE, 32'h0, 1'h0);
    chk("per_addr", 32'hfff0_4000, r_paddr);
    chk("per_index", 8'hc1, r_pidx);
    chk("per_abort", 0, r_abort);
    acc(32'hffff_c004, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h0);
    chk("aic_sel", 1, r_aic);
    acc(32'hffff_d000, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h0);
    chk("aic_hole_req", 0, r_per);
    chk("aic_hole_abort", 0, r_abort);
    acc(32'hffc0_4000, 1'h1, mmc_pkg::SZ_WORD, 32'h5, 1'h0);
    chk("user_wr_req", 0, r_per);
    chk("user_wr_abort", 0, r_abort);
    acc(32'hffc0_4000, 1'h1, mmc_pkg::SZ_WORD, 32'h5, 1'h1);
    chk("sup_wr_req", 1, r_per);
  endtask

  task t_resets;
    do_reset(1'h0, 1'h0, 1'h1);
    chk("wd_boot_kept", 1, boot_mode_8bit);
    chk("wd_unmapped", 0, remapped);
    do_reset(1'h0, 1'h1, 1'h1);
    chk("both_resample", 0, boot_mode_8bit);
    acc(32'h0, 1'h0, mmc_pkg::SZ_WORD, 32'h0, 1'h1);
    chk("boot16_ebu", 1, r_ebu);
    chk("boot16_w16", 1, r_w16);
    clk_en <= 1'h0;
    remap_command_bit <= 1'h1;
    @(posedge sys_clk);
    remap_command_bit <= 1'h0;
    clk_en <= 1'h1;
    @(posedge sys_clk);
    chk("frozen_remap", 0, remapped);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end

  initial begin
    {resetn, external_reset_n, watchdog_reset, remap_command_bit, cpu_req, cpu_write, cpu_fetch} = 7'h0;
    {clk_en, boot_width_select, tristate_request_n, cpu_priv, slow_clock, early_read} = 6'h3d;
    {sdiv, cpu_size, cpu_addr, cpu_wdata, err_total, total_checks} = '0;
    bank_enable = 8'h03;
    bank_base = {72'h0, 12'h010, 12'h004};
    bank_size_code = 24'h0;
    bank_wait_states = 24'h18;
    bank_float_cycles = 24'h28;
    bank_write_protect = 8'h02;
    bank_width16 = 8'h01;
    bank_byte_write_mode = 8'h00;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'h1;
    do_reset(1'h1, 1'h1, 1'h0);
    t_boot;
    t_remap;
    t_aborts;
    t_periph;
    t_resets;
    report_and_stop;
  end
endmodule
